// *** sch_pkg.sv ***
// sch_pkg: shared constants of the storey clock signal handler and its master end
// assumes: pclk at 250 MHz on both ends, link carried by sch_link_if
`default_nettype none

package sch_pkg;

  // ****************************************************************
  // link frame layout
  // ****************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          CODE_W      = 4;
  localparam int          FRAME_W     = ADDR_W + CODE_W;
  localparam int          BITCNT_W    = 4;
  localparam logic [7:0]  BCAST_ADDR  = 8'hFF;

  // link command codes
  localparam logic [3:0]  CODE_RTS     = 4'h1;
  localparam logic [3:0]  CODE_RUN_MARK = 4'h2;
  localparam logic [3:0]  CODE_SELECT  = 4'h3;
  localparam logic [3:0]  CODE_CAL     = 4'h4;
  localparam logic [3:0]  CODE_ENABLE  = 4'h5;
  localparam logic [3:0]  CODE_DISABLE = 4'h6;
  localparam logic [3:0]  CODE_BEACON  = 4'h7;
  localparam logic [3:0]  CODE_REBOOT  = 4'h8;
  // master-only sequences, never sent on the link
  localparam logic [3:0]  SEQ_RUN_START = 4'h9;
  localparam logic [3:0]  SEQ_RUN_STOP  = 4'hA;
  localparam logic [3:0]  SEQ_BEACON    = 4'hB;

  // ****************************************************************
  // master register map (apb, byte addresses)
  // ****************************************************************
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_CTRL     = 8'h08;
  localparam logic [7:0]  OFF_ECHO_DLY = 8'h0C;
  localparam int          CMD_ADDR_LSB = 0;
  localparam int          CMD_CODE_LSB = 8;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_ECHO    = 1;
  localparam int          CTRL_AUTO    = 0;
  localparam logic        CTRL_AUTO_RST = 1'b0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_MHZ        = 250;
  localparam int          RTS_MAX_MS     = 800;
  localparam int          RTS_PERIOD_CYC = RTS_MAX_MS * 1000 * CLK_MHZ;
  localparam int          LINK_HALF_CYC  = 16;
  localparam int          ECHO_CYC       = 8;
  localparam int          BEACON_ENA_US  = 5;
  localparam int          BEACON_DIS_US  = 10;

  // storey data path defaults
  localparam int          TSC_W_DEF = 32;
  localparam int          HIT_W_DEF = 16;

endpackage

`default_nettype wire

// *** sch_link_if.sv ***
// sch_link_if: clock-borne signal link between master and storey end
// assumes: master drives clock and command line, storey drives echo line
`default_nettype none

interface sch_link_if;
  logic link_clk;
  logic link_cmd;
  logic link_echo;

  modport master
  (
    output link_clk,
    output link_cmd,
    input  link_echo
  );

  modport storey
  (
    input  link_clk,
    input  link_cmd,
    output link_echo
  );
endinterface

`default_nettype wire

// *** sch_storey_end.sv ***
// sch_storey_end: storey side of the clock signal link
// assumes: link lines are asynchronous to pclk; straps stable at reset release
`default_nettype none

// What this block does
// - master resets digitiser clocks every 800 ms
// - count every timestamp reset pulse addressed to own or broadcast address
// - tag readout data with counter value
// - run-start marker clears the counter
// - accept own or broadcast address only
// - selected module echoes calibration signal
// - select addressed module only, others deselect
// - broadcast disable stops data, enable resumes
// - master pairs enable/disable with run commands
// - beacon signal fires beacon, no reconfiguration
// - master enable within 5 us of beacon
// - master disable 0 to 10 us after beacon
// - addressed reboot signal forces local reboot
// - configuration taken at power-on
module sch_storey_end
#(
  parameter int TSC_W = sch_pkg::TSC_W_DEF,
  parameter int HIT_W = sch_pkg::HIT_W_DEF
)
(
  sch_link_if.storey                     link,
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [sch_pkg::ADDR_W-1:0] cfg_addr,
  input  wire logic                      cfg_beacon_owner,
  input  wire logic                      hit_valid,
  input  wire logic                      hit_sop,
  input  wire logic [HIT_W-1:0]          hit_data,
  output logic                           out_valid,
  output logic                           out_sop,
  output logic      [HIT_W-1:0]          out_data,
  output logic      [TSC_W-1:0]          out_tsc,
  output logic      [TSC_W-1:0]          tsc_count,
  output logic                           ts_reset_pulse,
  output logic                           flow_enable,
  output logic                           cal_selected,
  output logic                           beacon_fire,
  output logic                           reboot_req,
  output logic                           cfg_done
);
  import sch_pkg::*;

  typedef enum logic {RX_IDLE, RX_SHIFT} sch_rx_state_t;

  // ****************************************************************
  // power-on configuration
  // ****************************************************************
  logic [ADDR_W-1:0] my_addr_reg;
  logic              beacon_owner_reg;
  logic              cfg_done_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      my_addr_reg      <= 8'h00;
      beacon_owner_reg <= 1'b0;
      cfg_done_reg     <= 1'b0;
    end
    else if (!cfg_done_reg)
    begin
      my_addr_reg      <= cfg_addr;
      beacon_owner_reg <= cfg_beacon_owner;
      cfg_done_reg     <= 1'b1;
    end
  end

  // ****************************************************************
  // link input synchronisers
  // ****************************************************************
  logic [1:0] clk_sync_reg;
  logic [1:0] cmd_sync_reg;
  logic       clk_prev_reg;
  logic       clk_rise;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_sync_reg <= 2'h0;
      cmd_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[0], link.link_clk};
      cmd_sync_reg <= {cmd_sync_reg[0], link.link_cmd};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;

  // ****************************************************************
  // frame receiver
  // ****************************************************************
  sch_rx_state_t         rx_state_reg;
  logic [FRAME_W-1:0]    rx_shift_reg;
  logic [BITCNT_W-1:0]   rx_cnt_reg;
  logic                  frame_done_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg   <= RX_IDLE;
      rx_shift_reg   <= '0;
      rx_cnt_reg     <= '0;
      frame_done_reg <= 1'b0;
    end
    else
    begin
      frame_done_reg <= 1'b0;
      if (clk_rise)
      begin
        unique case (rx_state_reg)
          RX_IDLE:
          begin
            if (cmd_sync_reg[1] && cfg_done_reg)
            begin
              rx_state_reg <= RX_SHIFT;
              rx_cnt_reg   <= '0;
            end
          end
          RX_SHIFT:
          begin
            rx_shift_reg <= {rx_shift_reg[FRAME_W-2:0], cmd_sync_reg[1]};
            rx_cnt_reg   <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == BITCNT_W'(FRAME_W - 1))
            begin
              rx_state_reg   <= RX_IDLE;
              frame_done_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // frame decode
  // ****************************************************************
  logic [ADDR_W-1:0] f_addr;
  logic [CODE_W-1:0] f_code;
  logic              f_mine;
  logic              f_accept;

  assign f_addr   = rx_shift_reg[FRAME_W-1 -: ADDR_W];
  assign f_code   = rx_shift_reg[CODE_W-1:0];
  assign f_mine   = (f_addr == my_addr_reg);
  assign f_accept = frame_done_reg & (f_mine | (f_addr == BCAST_ADDR));

  // ****************************************************************
  // timestamp reset counter
  // ****************************************************************
  logic [TSC_W-1:0] tsc_reg;
  logic             ts_pulse_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsc_reg      <= '0;
      ts_pulse_reg <= 1'b0;
    end
    else
    begin
      ts_pulse_reg <= f_accept && (f_code == CODE_RTS);
      if (f_accept && (f_code == CODE_RUN_MARK))
        tsc_reg <= '0;
      else if (f_accept && (f_code == CODE_RTS))
        tsc_reg <= tsc_reg + TSC_W'(1);
    end
  end

  // ****************************************************************
  // flow control, calibration, beacon, reboot
  // ****************************************************************
  logic       flow_en_reg;
  logic       cal_sel_reg;
  logic [3:0] echo_cnt_reg;
  logic       echo_reg;
  logic       beacon_reg;
  logic       reboot_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flow_en_reg <= 1'b0;
    else if (f_accept && (f_code == CODE_ENABLE))
      flow_en_reg <= 1'b1;
    else if (f_accept && (f_code == CODE_DISABLE))
      flow_en_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_sel_reg <= 1'b0;
    else if (frame_done_reg && (f_code == CODE_SELECT))
      cal_sel_reg <= f_mine;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      echo_cnt_reg <= 4'h0;
      echo_reg     <= 1'b0;
    end
    else
    begin
      if (f_accept && (f_code == CODE_CAL) && cal_sel_reg)
        echo_cnt_reg <= 4'(ECHO_CYC);
      else if (echo_cnt_reg != 4'h0)
        echo_cnt_reg <= echo_cnt_reg - 4'h1;
      echo_reg <= (f_accept && (f_code == CODE_CAL) && cal_sel_reg)
                  || (echo_cnt_reg > 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      beacon_reg <= 1'b0;
      reboot_reg <= 1'b0;
    end
    else
    begin
      beacon_reg <= f_accept && (f_code == CODE_BEACON) && beacon_owner_reg;
      reboot_reg <= frame_done_reg && f_mine && (f_code == CODE_REBOOT);
    end
  end

  // ****************************************************************
  // hit path with timestamp tag
  // ****************************************************************
  logic pass_reg;
  logic pass_now;

  assign pass_now = hit_sop ? flow_en_reg : pass_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pass_reg  <= 1'b0;
      out_valid <= 1'b0;
      out_sop   <= 1'b0;
      out_data  <= '0;
      out_tsc   <= '0;
    end
    else
    begin
      if (hit_valid && hit_sop)
        pass_reg <= flow_en_reg;
      out_valid <= hit_valid && pass_now;
      if (hit_valid && pass_now)
      begin
        out_sop  <= hit_sop;
        out_data <= hit_data;
        out_tsc  <= tsc_reg;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.link_echo  = echo_reg;
  assign tsc_count       = tsc_reg;
  assign ts_reset_pulse  = ts_pulse_reg;
  assign flow_enable     = flow_en_reg;
  assign cal_selected    = cal_sel_reg;
  assign beacon_fire     = beacon_reg;
  assign reboot_req      = reboot_reg;
  assign cfg_done        = cfg_done_reg;

endmodule // sch_storey_end

`default_nettype wire

// *** sch_master_end.sv ***
// sch_master_end: shore-side master of the clock signal link, apb controlled
// assumes: apb master on pclk; storey end on the far side of sch_link_if
//
// Decided for this implementation: the APB register port and the address map.
`default_nettype none

module sch_master_end
#(
  parameter int RTS_PERIOD = sch_pkg::RTS_PERIOD_CYC,
  parameter int LINK_HALF  = sch_pkg::LINK_HALF_CYC
)
(
  sch_link_if.master   link,
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    psel,
  input  wire logic    penable,
  input  wire logic    pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr
);
  import sch_pkg::*;

  // ****************************************************************
  // sequence tables
  // ****************************************************************
  function automatic logic [3:0] step_code(input logic [3:0] sw, input logic [1:0] st);
    case (sw)
      SEQ_RUN_START: step_code = (st == 2'h0) ? CODE_RUN_MARK : CODE_ENABLE;
      SEQ_RUN_STOP:  step_code = CODE_DISABLE;
      SEQ_BEACON:    step_code = (st == 2'h0) ? CODE_ENABLE :
                                 (st == 2'h1) ? CODE_BEACON : CODE_DISABLE;
      default:       step_code = sw;
    endcase
  endfunction

  function automatic logic step_last(input logic [3:0] sw, input logic [1:0] st);
    case (sw)
      SEQ_RUN_START: step_last = (st == 2'h1);
      SEQ_BEACON:    step_last = (st == 2'h2);
      default:       step_last = 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // link clock divider
  // ****************************************************************
  logic [7:0] half_cnt_reg;
  logic       lclk_reg;
  logic       fall_tick;

  assign fall_tick = (half_cnt_reg == 8'(LINK_HALF - 1)) && lclk_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_cnt_reg <= 8'h00;
      lclk_reg     <= 1'b0;
    end
    else if (half_cnt_reg == 8'(LINK_HALF - 1))
    begin
      half_cnt_reg <= 8'h00;
      lclk_reg     <= ~lclk_reg;
    end
    else
      half_cnt_reg <= half_cnt_reg + 8'h01;
  end

  // ****************************************************************
  // sequencer and frame transmitter
  // ****************************************************************
  logic [3:0]         seq_code_reg;
  logic [1:0]         seq_step_reg;
  logic [ADDR_W-1:0]  seq_addr_reg;
  logic               seq_busy_reg;
  logic               rts_pend_reg;
  logic [31:0]        rts_cnt_reg;
  logic               auto_rts_reg;
  logic [FRAME_W:0]   tx_shift_reg;
  logic [BITCNT_W-1:0] tx_left_reg;
  logic               tx_cal_reg;
  logic               cmd_reg;
  logic               rts_go;
  logic               take;
  logic [3:0]         cur_code;
  logic [ADDR_W-1:0]  cur_addr;
  logic               cmd_wr;

  assign rts_go   = rts_pend_reg && !(seq_busy_reg && (seq_step_reg != 2'h0));
  assign take     = fall_tick && (tx_left_reg == '0) && (rts_go || seq_busy_reg);
  assign cur_code = rts_go ? CODE_RTS : step_code(seq_code_reg, seq_step_reg);
  assign cur_addr = (rts_go || (seq_code_reg >= SEQ_RUN_START && cur_code != CODE_BEACON))
                    ? BCAST_ADDR : seq_addr_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rts_cnt_reg  <= 32'h0000_0000;
      rts_pend_reg <= 1'b0;
    end
    else
    begin
      if (!auto_rts_reg || rts_cnt_reg == 32'(RTS_PERIOD - 1))
        rts_cnt_reg <= 32'h0000_0000;
      else
        rts_cnt_reg <= rts_cnt_reg + 32'h0000_0001;
      if (auto_rts_reg && rts_cnt_reg == 32'(RTS_PERIOD - 1))
        rts_pend_reg <= 1'b1;
      else if (take && rts_go)
        rts_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_code_reg <= 4'h0;
      seq_step_reg <= 2'h0;
      seq_addr_reg <= 8'h00;
      seq_busy_reg <= 1'b0;
    end
    else if (cmd_wr)
    begin
      seq_code_reg <= pwdata[CMD_CODE_LSB +: CODE_W];
      seq_addr_reg <= pwdata[CMD_ADDR_LSB +: ADDR_W];
      seq_step_reg <= 2'h0;
      seq_busy_reg <= 1'b1;
    end
    else if (take && !rts_go)
    begin
      if (step_last(seq_code_reg, seq_step_reg))
        seq_busy_reg <= 1'b0;
      else
        seq_step_reg <= seq_step_reg + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_shift_reg <= '0;
      tx_left_reg  <= '0;
      tx_cal_reg   <= 1'b0;
      cmd_reg      <= 1'b0;
    end
    else if (take)
    begin
      cmd_reg      <= 1'b1;
      tx_shift_reg <= {cur_addr, cur_code, 1'b0};
      tx_left_reg  <= BITCNT_W'(FRAME_W + 1);
      tx_cal_reg   <= (cur_code == CODE_CAL);
    end
    else if (fall_tick && tx_left_reg != '0)
    begin
      cmd_reg      <= tx_shift_reg[FRAME_W];
      tx_shift_reg <= {tx_shift_reg[FRAME_W-1:0], 1'b0};
      tx_left_reg  <= tx_left_reg - 4'h1;
    end
  end

  // ****************************************************************
  // calibration echo delay measurement
  // ****************************************************************
  logic [1:0]  echo_sync_reg;
  logic        echo_prev_reg;
  logic        meas_on_reg;
  logic [31:0] meas_cnt_reg;
  logic [31:0] echo_dly_reg;
  logic        echo_seen_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      echo_sync_reg <= 2'h0;
      echo_prev_reg <= 1'b0;
      meas_on_reg   <= 1'b0;
      meas_cnt_reg  <= 32'h0000_0000;
      echo_dly_reg  <= 32'h0000_0000;
      echo_seen_reg <= 1'b0;
    end
    else
    begin
      echo_sync_reg <= {echo_sync_reg[0], link.link_echo};
      echo_prev_reg <= echo_sync_reg[1];
      if (fall_tick && tx_cal_reg && tx_left_reg == 4'h2)
      begin
        meas_on_reg  <= 1'b1;
        meas_cnt_reg <= 32'h0000_0000;
      end
      else if (meas_on_reg && echo_sync_reg[1] && !echo_prev_reg)
      begin
        meas_on_reg   <= 1'b0;
        echo_dly_reg  <= meas_cnt_reg;
      end
      else if (meas_on_reg && meas_cnt_reg != 32'hFFFF_FFFF)
        meas_cnt_reg <= meas_cnt_reg + 32'h0000_0001;
      if (meas_on_reg && echo_sync_reg[1] && !echo_prev_reg)
        echo_seen_reg <= 1'b1;
      else if (cmd_wr && pwdata[CMD_CODE_LSB +: CODE_W] == CODE_CAL)
        echo_seen_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic setup;
  logic access;
  logic bad_cmd;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign bad_cmd = seq_busy_reg
                   || pwdata[CMD_CODE_LSB +: CODE_W] == 4'h0
                   || pwdata[CMD_CODE_LSB +: CODE_W] > SEQ_BEACON;
  assign cmd_wr  = access && pwrite && paddr == OFF_CMD && !pslverr;
  assign pready  = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      auto_rts_reg <= CTRL_AUTO_RST;
    else if (access && pwrite && paddr == OFF_CTRL)
      auto_rts_reg <= pwdata[CTRL_AUTO];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      unique case (paddr)
        OFF_CMD:      pslverr <= !pwrite || bad_cmd;
        OFF_STATUS:
        begin
          prdata[STAT_BUSY] <= seq_busy_reg || rts_pend_reg || tx_left_reg != '0;
          prdata[STAT_ECHO] <= echo_seen_reg;
          pslverr           <= pwrite;
        end
        OFF_CTRL:     prdata[CTRL_AUTO] <= auto_rts_reg;
        OFF_ECHO_DLY:
        begin
          prdata  <= echo_dly_reg;
          pslverr <= pwrite;
        end
        default:      pslverr <= 1'b1;
      endcase
    end
  end

  assign link.link_clk = lclk_reg;
  assign link.link_cmd = cmd_reg;

endmodule // sch_master_end

`default_nettype wire

// *** sch_link_asserts.sv ***
// sch_link_asserts: timing checks on the link wires
// assumes: instantiated beside sch_link_if, on pclk and presetn
`default_nettype none
module sch_link_asserts
#(
  parameter int LINK_HALF = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clk,
  input wire logic link_cmd,
  input wire logic link_echo
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // link timing
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_clk_high: assert property ($rose(link_clk) |-> ##LINK_HALF $fell(link_clk))
    else $error("link clock high phase");
  a_clk_low: assert property ($fell(link_clk) |-> ##LINK_HALF $rose(link_clk))
    else $error("link clock low phase");
  a_cmd_clk_low: assert property ($changed(link_cmd) |-> !link_clk)
    else $error("command moved in high phase");
  a_cmd_bit_held: assert property ($changed(link_cmd) |=> $stable(link_cmd)[*8])
    else $error("command bit short");
  a_echo_width: assert property ($rose(link_echo) |-> link_echo[*8] ##1 !link_echo)
    else $error("echo width");
  a_echo_spacing: assert property ($fell(link_echo) |-> !link_echo[*8])
    else $error("echo retriggered");
  a_echo_clk_high: assert property ($rose(link_echo) |-> link_clk)
    else $error("echo off clock high phase");
  a_echo_cmd_low: assert property ($rose(link_echo) |-> !link_cmd)
    else $error("echo not after last bit");
  c_echo: cover property ($rose(link_echo));
  c_frame: cover property ($rose(link_cmd));
  c_clk: cover property ($fell(link_clk));
endmodule // sch_link_asserts
`default_nettype wire

// *** sch_tb.sv ***
// testbench: both link ends joined by sch_link_if, master set up over apb
// assumes: package, interface, both ends and checker compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sch_pkg::*;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        cfg_beacon_owner = 1'h1, hit_valid = 1'h0, hit_sop = 1'h0;
  logic [7:0]  paddr = 8'h00, cfg_addr = 8'h21;
  logic [15:0] hit_data = 16'h0000, out_data;
  logic [31:0] pwdata = 32'h0, prdata, rd, out_tsc, tsc_count;
  logic        pready, pslverr, er, out_valid, out_sop, ts_reset_pulse, flow_enable;
  logic        cal_selected, beacon_fire, reboot_req, cfg_done;
  int          err_count = 0, tests_run = 0, n_rts = 0, n_bcn = 0, n_rbt = 0, k;
  sch_link_if u_link();
  sch_master_end #(.RTS_PERIOD(200)) u_sch_master_end (.link(u_link.master), .pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  sch_storey_end u_sch_storey_end (.link(u_link.storey), .pclk, .presetn, .cfg_addr,
    .cfg_beacon_owner, .hit_valid, .hit_sop, .hit_data, .out_valid, .out_sop,
    .out_data, .out_tsc, .tsc_count, .ts_reset_pulse, .flow_enable, .cal_selected,
    .beacon_fire, .reboot_req, .cfg_done);
  sch_link_asserts #(.LINK_HALF(16)) u_chk (.pclk, .presetn, .link_clk(u_link.link_clk),
    .link_cmd(u_link.link_cmd), .link_echo(u_link.link_echo));
  always #2 pclk = ~pclk;
  always @(posedge pclk) n_rts += ts_reset_pulse;
  always @(posedge pclk) n_bcn += beacon_fire;
  always @(posedge pclk) n_rbt += reboot_req;
  // ****
  // tasks
  // ****
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk) penable <= 1'h1;
    @(posedge pclk);
    for (i = 0; i < 50 && pready !== 1'h1; i++)
      @(posedge pclk);
    if (pready !== 1'h1) err_count++;
    if (pready !== 1'h1) wrap_up();
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] a, input logic [3:0] c);
    int i;
    apb(1'h1, OFF_CMD, {20'h0, c, a});
    rd = 32'h1;
    for (i = 0; i < 2000 && rd[STAT_BUSY] !== 1'h0; i++)
      apb(1'h0, OFF_STATUS, 32'h0);
    if (rd[STAT_BUSY] !== 1'h0) err_count++;
    if (rd[STAT_BUSY] !== 1'h0) wrap_up();
    repeat (8) @(posedge pclk);
  endtask
  task automatic hit(input logic ev, input logic [31:0] ts);
    {hit_valid, hit_sop, hit_data} <= {2'h3, 16'hC35A};
    @(posedge pclk) {hit_valid, hit_sop} <= 2'h0;
    @(negedge pclk);
    chk("valid", ev, out_valid);
    if (ev) chk("tag", ts, out_tsc);
    if (ev) chk("data", 32'hC35A, out_data);
    if (ev) chk("sop", 32'h1, out_sop);
    @(posedge pclk);
  endtask
  task automatic t_count();
    cfg_addr <= 8'h33;
    send(8'h21, CODE_RTS);
    send(BCAST_ADDR, CODE_RTS);
    send(8'h22, CODE_RTS);
    chk("rts", 32'h2, n_rts);
    chk("tsc", 32'h2, tsc_count);
  endtask
  task automatic t_flow();
    send(BCAST_ADDR, CODE_ENABLE);
    chk("flow", 32'h1, flow_enable);
    hit(1'h1, 32'h2);
    send(BCAST_ADDR, CODE_DISABLE);
    chk("flow", 32'h0, flow_enable);
    hit(1'h0, 32'h2);
    send(BCAST_ADDR, CODE_RUN_MARK);
    chk("tsc", 32'h0, tsc_count);
  endtask
  task automatic t_cal();
    send(8'h21, CODE_SELECT);
    chk("sel", 32'h1, cal_selected);
    send(8'h21, CODE_CAL);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("echo", 32'h1, rd[STAT_ECHO]);
    apb(1'h0, OFF_ECHO_DLY, 32'h0);
    chk("delay", 32'h1, rd > LINK_HALF_CYC && rd < 2 * LINK_HALF_CYC);
    send(8'h22, CODE_SELECT);
    chk("sel", 32'h0, cal_selected);
    send(8'h21, CODE_CAL);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk("echo", 32'h0, rd[STAT_ECHO]);
  endtask
  task automatic t_act();
    send(8'h21, CODE_BEACON);
    chk("beacon", 32'h1, n_bcn);
    send(8'h21, CODE_REBOOT);
    send(BCAST_ADDR, CODE_REBOOT);
    chk("reboot", 32'h1, n_rbt);
    send(8'h21, SEQ_BEACON);
    chk("beacon", 32'h2, n_bcn);
    chk("flow", 32'h0, flow_enable);
    send(BCAST_ADDR, CODE_RTS);
    send(BCAST_ADDR, SEQ_RUN_START);
    chk("flow", 32'h1, flow_enable);
    hit(1'h1, 32'h0);
    send(BCAST_ADDR, SEQ_RUN_STOP);
    chk("flow", 32'h0, flow_enable);
  endtask
  task automatic t_ctrl();
    apb(1'h1, 8'h40, 32'h0);
    chk("unmapped", 32'h1, er);
    apb(1'h1, OFF_CTRL, 32'h1);
    k = n_rts;
    repeat (2000) @(posedge pclk);
    apb(1'h1, OFF_CTRL, 32'h0);
    repeat (600) @(posedge pclk);
    chk("auto", 32'h1, n_rts - k >= 3);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    @(negedge pclk);
    chk("cfg", 32'h1, cfg_done);
    @(posedge pclk);
    t_count();
    t_flow();
    t_cal();
    t_act();
    t_ctrl();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
